/* File: src/pbs_defs.svh */
// constants for the pipelined burst sram: sizes, burst and sleep timing
// assumes it is included by bare name wherever a figure is needed
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

// storage shape: word address bits, byte lanes, data bits per lane (parity bit not counted)
`define PBS_ADDR_W 20
`define PBS_BYTES 4
`define PBS_BYTE_W 8

// write data buffer depth in words
`define PBS_FIFO_DEPTH 16

// burst counter: two low address bits, step of one beat
`define PBS_BEAT_W 2
`define PBS_BEAT_ONE 2'h1
`define PBS_BEAT_ZERO 2'h0

// sleep entry and exit time, in clock periods, and its cycle count
`define PBS_SLEEP_TCYC 2
`define PBS_SLEEP_CNT (`PBS_SLEEP_TCYC)
`define PBS_SLEEP_CNT_W 2
`define PBS_SLEEP_LAST 2'h0

`endif

/* File: src/pbs_pkg.sv */
// types shared by the pipelined burst sram
// assumes pbs_defs.svh supplies the numeric constants
package pbs_pkg;

    // sleep sequencer states, one-hot
    typedef enum logic [3:0] {
        PBS_AWAKE  = 4'h1,
        PBS_ENTER  = 4'h2,
        PBS_ASLEEP = 4'h4,
        PBS_EXIT   = 4'h8
    } pbs_sleep_t;

endpackage

/* File: src/pbs_burst_sram.sv */
// pipelined burst sram core with its write data buffer
// assumes a host on core_clk drives the synchronous pins and resolves the
// shared data wire from dataOe and parityBusOe
//
// Functional notes
// - register inputs and outputs on rising edge
// - clock_qualify_n high freezes every state
// - selected load with write enable high reads
// - read word driven one clock later
// - output enable gates read data drivers
// - new operation accepted every clock
// - deselect floats bus after next rise
// - burst counter gives four beats
// - burstOrder low linear, high interleaved
// - counter wraps within two address bits
// - advance ignores chip selects and write
// - access type held for whole burst
// - selected load with write low writes
// - bus floats in write data cycle
// - write data taken second rise later
// - only selected bytes are written
// - sleep keeps data, two cycles transition
// - linear order adds one modulo four
// - interleaved order xors beat index
// - comes out of reset deselected, floating
`timescale 1ns/100ps
`include "pbs_defs.svh"

// small synchronous fifo, one word in and one word out per clock
module pbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `PBS_FIFO_DEPTH
) (
    // clock, reset, freeze
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic enable,
    // filling side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // draining side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem; // word storage
        logic [PW-1:0] wrPtr; // next slot to fill
        logic [PW-1:0] rdPtr; // oldest word
        logic [PW:0] count; // words held
    } pbs_fifo_st_t;

    pbs_fifo_st_t r_reg;
    pbs_fifo_st_t r_next;
    logic pushFire;
    logic popFire;

    // honest flags straight from the count
    assign inReady = (r_reg.count != (PW + 1)'(DEPTH));
    assign outValid = (r_reg.count != '0);
    assign outData = r_reg.mem[r_reg.rdPtr];
    assign pushFire = enable && inValid && inReady;
    assign popFire = enable && outValid && outReady;

    // pointer and count update; push and pop may share a cycle
    always_comb begin
        r_next = r_reg;
        if (pushFire) begin
            r_next.mem[r_reg.wrPtr] = inData;
            r_next.wrPtr = PW'(r_reg.wrPtr + 1'b1);
        end
        if (popFire) begin
            r_next.rdPtr = PW'(r_reg.rdPtr + 1'b1);
        end
        if (pushFire && !popFire) begin
            r_next.count = (PW + 1)'(r_reg.count + 1'b1);
        end else if (popFire && !pushFire) begin
            r_next.count = (PW + 1)'(r_reg.count - 1'b1);
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end
endmodule

// the sram device logic
module pbs_burst_sram #(
    parameter int ADDR_W = `PBS_ADDR_W,
    parameter int BYTES = `PBS_BYTES,
    parameter int BYTE_W = `PBS_BYTE_W,
    parameter int FIFO_DEPTH = `PBS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // synchronous controls from the host
    input wire logic clock_qualify_n,
    input wire logic chip_select_a_n,
    input wire logic chip_select_b,
    input wire logic chip_select_c_n,
    input wire logic advance_or_load,
    input wire logic writeEnableN,
    input wire logic [BYTES-1:0] byte_write_select_n,
    input wire logic [ADDR_W-1:0] address,
    // static and asynchronous pins
    input wire logic burstOrder,
    input wire logic outputEnableN,
    input wire logic sleep_request,
    // shared data and parity bus, split in three
    input wire logic [BYTES*BYTE_W-1:0] dataIn,
    output logic [BYTES*BYTE_W-1:0] dataOut,
    output logic dataOe,
    input wire logic [BYTES-1:0] parity_bus_in,
    output logic [BYTES-1:0] parity_bus_out,
    output logic parityBusOe
);
    localparam int LANE_W = BYTE_W + 1; // data byte plus its parity bit
    localparam int WORDS = 1 << ADDR_W;
    localparam int FW = ADDR_W + BYTES + BYTES * LANE_W;

    typedef struct packed {
        logic sleepMeta; // first sync stage, read only by sleepSync
        logic sleepSync;
        logic oeMeta; // first sync stage, read only by oeSync
        logic oeSync; // active low, high means drivers off
        pbs_pkg::pbs_sleep_t sleepState;
        logic [`PBS_SLEEP_CNT_W-1:0] sleepCnt;
        logic s1Valid; // burst active, beat in address stage
        logic s1Write; // access type caught at burst start
        logic [ADDR_W-1:0] s1Addr;
        logic [`PBS_BEAT_W-1:0] s1Base; // first beat low bits
        logic [`PBS_BEAT_W-1:0] s1Beat; // beat index
        logic [BYTES-1:0] s1Bw;
        logic s2Valid; // write waiting for its data
        logic [ADDR_W-1:0] s2Addr;
        logic [BYTES-1:0] s2Bw;
        logic [BYTES*BYTE_W-1:0] dataOut;
        logic [BYTES-1:0] parOut;
        logic busOe;
    } pbs_st_t;

    localparam pbs_st_t ST_RESET = '{
        sleepState: pbs_pkg::PBS_AWAKE,
        oeMeta: 1'b1,
        oeSync: 1'b1,
        default: '0
    };

    pbs_st_t r_reg;
    pbs_st_t r_next;
    logic enable; // clock qualified this edge
    logic awake;
    logic selected;
    logic anyByte;
    logic [`PBS_BEAT_W-1:0] beatNext;
    logic [`PBS_BEAT_W-1:0] linNext;
    logic [`PBS_BEAT_W-1:0] intNext;
    logic fifoInValid;
    logic fifoInReady;
    logic [FW-1:0] fifoInData;
    logic fifoOutValid;
    logic [FW-1:0] fifoOutData;
    logic drainFire;
    logic [ADDR_W-1:0] headAddr;
    logic [BYTES-1:0] headBw;
    logic [BYTES-1:0][LANE_W-1:0] headLanes;
    logic [BYTES-1:0][LANE_W-1:0] inLanes;
    logic [BYTES-1:0][LANE_W-1:0] fwdLanes;

    // pack the pins of one word into parity-topped lanes
    function automatic logic [BYTES-1:0][LANE_W-1:0] packLanes(
        input logic [BYTES*BYTE_W-1:0] d,
        input logic [BYTES-1:0] p
    );
        logic [BYTES-1:0][LANE_W-1:0] w;
        for (int i = 0; i < BYTES; i++) begin
            w[i] = {p[i], d[i*BYTE_W +: BYTE_W]};
        end
        return w;
    endfunction

    assign enable = !clock_qualify_n;
    assign awake = (r_reg.sleepState == pbs_pkg::PBS_AWAKE);
    assign selected = !chip_select_a_n && chip_select_b && !chip_select_c_n;
    assign anyByte = !(&r_reg.s2Bw);
    // next beat, wrapping inside the two low bits
    assign beatNext = `PBS_BEAT_W'(r_reg.s1Beat + `PBS_BEAT_ONE);
    assign linNext = `PBS_BEAT_W'(r_reg.s1Base + beatNext);
    assign intNext = r_reg.s1Base ^ beatNext;

    // write data enters the buffer at the second rise after its address
    assign inLanes = packLanes(dataIn, parity_bus_in);
    assign fifoInValid = enable && awake && r_reg.s2Valid && anyByte;
    assign fifoInData = {r_reg.s2Addr, r_reg.s2Bw, inLanes};
    assign {headAddr, headBw, headLanes} = fifoOutData;
    // draining stalls while asleep so stored data is left untouched
    assign drainFire = enable && awake && fifoOutValid;

    // write buffer between the bus and the array
    pbs_fifo #(
        .WIDTH(FW),
        .DEPTH(FIFO_DEPTH)
    ) writeBuf (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .enable(enable),
        .inValid(fifoInValid),
        .inData(fifoInData),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(awake)
    );

    // one memory per byte lane, with forwarding of writes not yet stored
    for (genvar g = 0; g < BYTES; g++) begin : gLane
        logic [LANE_W-1:0] laneMem [0:WORDS-1];

        // only lanes whose select was low are stored
        always_ff @(posedge core_clk) begin
            if (drainFire && !headBw[g]) begin
                laneMem[headAddr] <= headLanes[g];
            end
        end

        // newest copy wins: pins, then buffer head, then array
        always_comb begin
            fwdLanes[g] = laneMem[r_reg.s1Addr];
            if (fifoOutValid && !headBw[g] && headAddr == r_reg.s1Addr) begin
                fwdLanes[g] = headLanes[g];
            end
            if (fifoInValid && fifoInReady && !r_reg.s2Bw[g]
                && r_reg.s2Addr == r_reg.s1Addr) begin
                fwdLanes[g] = inLanes[g];
            end
        end
    end

    // next state of the whole pipeline
    always_comb begin
        r_next = r_reg;
        if (enable) begin
            // asynchronous pins pass two flops first
            r_next.sleepMeta = sleep_request;
            r_next.sleepSync = r_reg.sleepMeta;
            r_next.oeMeta = outputEnableN;
            r_next.oeSync = r_reg.oeMeta;
            // sleep sequencer, two cycles each way
            case (r_reg.sleepState)
                pbs_pkg::PBS_AWAKE: begin
                    if (r_reg.sleepSync) begin
                        r_next.sleepState = pbs_pkg::PBS_ENTER;
                        r_next.sleepCnt =
                            `PBS_SLEEP_CNT_W'(`PBS_SLEEP_CNT - 1);
                    end
                end
                pbs_pkg::PBS_ENTER: begin
                    if (r_reg.sleepCnt == `PBS_SLEEP_LAST) begin
                        r_next.sleepState = pbs_pkg::PBS_ASLEEP;
                    end else begin
                        r_next.sleepCnt = `PBS_SLEEP_CNT_W'(r_reg.sleepCnt - 1);
                    end
                end
                pbs_pkg::PBS_ASLEEP: begin
                    if (!r_reg.sleepSync) begin
                        r_next.sleepState = pbs_pkg::PBS_EXIT;
                        r_next.sleepCnt =
                            `PBS_SLEEP_CNT_W'(`PBS_SLEEP_CNT - 1);
                    end
                end
                pbs_pkg::PBS_EXIT: begin
                    if (r_reg.sleepCnt == `PBS_SLEEP_LAST) begin
                        r_next.sleepState = pbs_pkg::PBS_AWAKE;
                    end else begin
                        r_next.sleepCnt = `PBS_SLEEP_CNT_W'(r_reg.sleepCnt - 1);
                    end
                end
                default: begin
                    r_next.sleepState = pbs_pkg::PBS_AWAKE;
                end
            endcase
            // data stage: a read beat in the address stage reaches the bus, a write beat waits for its data
            r_next.busOe = 1'b0;
            r_next.s2Valid = 1'b0;
            if (r_reg.s1Valid && awake) begin
                if (r_reg.s1Write) begin
                    r_next.s2Valid = 1'b1;
                    r_next.s2Addr = r_reg.s1Addr;
                    r_next.s2Bw = r_reg.s1Bw;
                end else begin
                    for (int i = 0; i < BYTES; i++) begin
                        r_next.dataOut[i*BYTE_W +: BYTE_W] =
                            fwdLanes[i][BYTE_W-1:0];
                        r_next.parOut[i] = fwdLanes[i][BYTE_W];
                    end
                    r_next.busOe = !r_reg.oeSync;
                end
            end
            // address stage: a new beat every clock, no idle cycle
            if (!awake) begin
                r_next.s1Valid = 1'b0; // pending beats are dropped
            end else if (advance_or_load) begin
                r_next.s1Beat = beatNext;
                r_next.s1Addr[`PBS_BEAT_W-1:0] =
                    burstOrder ? intNext : linNext;
                r_next.s1Bw = byte_write_select_n;
            end else begin
                r_next.s1Valid = selected;
                r_next.s1Write = !writeEnableN;
                r_next.s1Addr = address;
                r_next.s1Base = address[`PBS_BEAT_W-1:0];
                r_next.s1Beat = `PBS_BEAT_ZERO;
                r_next.s1Bw = byte_write_select_n;
            end
        end
    end

    // input and output registers share this one rising edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_reg <= ST_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    // pins come straight from the registers
    assign dataOut = r_reg.dataOut;
    assign parity_bus_out = r_reg.parOut;
    assign dataOe = r_reg.busOe;
    assign parityBusOe = r_reg.busOe;

    // checks on the pipeline
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    readLatency_a: assert property (
        enable && awake && r_reg.s1Valid && !r_reg.s1Write && !r_reg.oeSync
        |=> dataOe && parityBusOe)
        else $error("read beat not driven one clock later");
    freezeHold_a: assert property (
        clock_qualify_n |=> $stable(r_reg))
        else $error("state moved on a frozen edge");
    writeFloat_a: assert property (
        enable && r_reg.s1Valid && r_reg.s1Write |=> !dataOe)
        else $error("bus driven in write data cycle");
    deselFloat_a: assert property (
        enable && awake && !advance_or_load && !selected
        ##1 enable |=> !dataOe)
        else $error("bus still driven after deselect");
    loadRead_a: assert property (
        enable && awake && !advance_or_load && selected && writeEnableN
        |=> r_reg.s1Valid && !r_reg.s1Write && r_reg.s1Addr == $past(address))
        else $error("read address not loaded");
    holdType_a: assert property (
        enable && awake && advance_or_load && r_reg.s1Valid
        |=> r_reg.s1Valid && r_reg.s1Write == $past(r_reg.s1Write)
        && r_reg.s1Addr[ADDR_W-1:`PBS_BEAT_W]
        == $past(r_reg.s1Addr[ADDR_W-1:`PBS_BEAT_W]))
        else $error("burst changed type or upper address");
    // beat index steps by one and the low bits follow base plus index
    linearStep_a: assert property (
        enable && awake && advance_or_load && !burstOrder
        |=> r_reg.s1Addr[`PBS_BEAT_W-1:0]
        == `PBS_BEAT_W'(r_reg.s1Base + r_reg.s1Beat)
        && r_reg.s1Beat == `PBS_BEAT_W'($past(r_reg.s1Beat) + `PBS_BEAT_ONE))
        else $error("linear burst step wrong");
    // beat index steps by one and the low bits follow base xor index
    interStep_a: assert property (
        enable && awake && advance_or_load && burstOrder
        |=> r_reg.s1Addr[`PBS_BEAT_W-1:0] == (r_reg.s1Base ^ r_reg.s1Beat)
        && r_reg.s1Beat == `PBS_BEAT_W'($past(r_reg.s1Beat) + `PBS_BEAT_ONE))
        else $error("interleaved burst step wrong");
    sleepEntry_a: assert property (
        enable && awake && r_reg.sleepSync ##1 enable ##1 enable
        |=> r_reg.sleepState == pbs_pkg::PBS_ASLEEP)
        else $error("sleep not reached in two cycles");
    sleepFloat_a: assert property (
        r_reg.sleepState == pbs_pkg::PBS_ASLEEP |-> !dataOe)
        else $error("bus driven while asleep");

    readAfterWrite_c: cover property (
        enable && r_reg.s1Valid && r_reg.s1Write
        ##1 enable && r_reg.s1Valid && !r_reg.s1Write);
    fullBurst_c: cover property (
        enable && r_reg.s1Valid && advance_or_load [*3]);
    partialWrite_c: cover property (
        fifoInValid && anyByte && (|r_reg.s2Bw));
    sleepCycle_c: cover property (
        r_reg.sleepState == pbs_pkg::PBS_EXIT ##1 awake);
endmodule

/* File: testbench/pbs_host_model.sv */
// host memory controller model facing the pipelined burst sram pins
// assumes the bench calls op once per clock and resolves nothing itself
`timescale 1ns/100ps

module pbs_host_model (
    // clock
    input wire logic core_clk,
    // levels wanted by the bench
    input wire logic order,
    input wire logic oeReq,
    input wire logic slpReq,
    // controls toward the sram
    output logic clock_qualify_n,
    output logic chip_select_a_n,
    output logic chip_select_b,
    output logic chip_select_c_n,
    output logic advance_or_load,
    output logic writeEnableN,
    output logic [3:0] byte_write_select_n,
    output logic [5:0] address,
    output logic burstOrder,
    output logic outputEnableN,
    output logic sleep_request,
    // shared bus, split
    output logic [31:0] dataIn,
    output logic [3:0] parity_bus_in,
    input wire logic [31:0] dataOut,
    input wire logic dataOe,
    input wire logic [3:0] parity_bus_out,
    input wire logic parityBusOe,
    // sticky: host drove against the sram
    output logic clash
);
    logic pw; // last presented op was a write beat
    logic p1; // write beat taken, data due next cycle
    logic drvEn; // host drives the bus now
    logic [35:0] pd, d1, drvD; // data travelling with those stages
    logic [35:0] floatD; // idle bus pattern, changes every cycle

    // idle bus never shows the last value, so stale data cannot pass
    assign dataIn = dataOe ? dataOut : drvEn ? drvD[31:0] : floatD[31:0];
    assign parity_bus_in = parityBusOe ? parity_bus_out :
        drvEn ? drvD[35:32] : floatD[35:32];

    // quiet, deselected start with output enable already low
    initial begin
        {clock_qualify_n, advance_or_load, burstOrder} = 3'h0;
        {chip_select_a_n, chip_select_b, chip_select_c_n} = 3'h5;
        {writeEnableN, outputEnableN, sleep_request} = 3'h4;
        byte_write_select_n = 4'hf;
        address = 6'h00;
        {pw, p1, drvEn, clash} = 4'h0;
        {pd, d1, drvD} = 108'h0;
        floatD = 36'h5_5555_5555;
    end

    // toggle idle pattern, flag any drive fight
    always @(posedge core_clk) begin
        floatD <= ~floatD;
        if (drvEn && (dataOe || parityBusOe)) begin
            clash <= 1'b1;
        end
    end

    // one bus cycle; q and oe show the sram outputs after this edge
    task automatic op(input logic cq, adv, sel, wen, wrt,
        input logic [5:0] a, input logic [3:0] bw, input logic [35:0] wd,
        output logic [35:0] q, output logic [1:0] oe);
        @(posedge core_clk);
        // a frozen edge takes nothing, so write data waits with it
        if (!clock_qualify_n) begin
            drvEn <= p1;
            drvD <= d1;
            p1 <= pw;
            d1 <= pd;
        end
        pw <= wrt;
        pd <= wd;
        clock_qualify_n <= cq;
        advance_or_load <= adv;
        chip_select_a_n <= ~sel;
        chip_select_b <= sel;
        chip_select_c_n <= ~sel;
        writeEnableN <= wen;
        byte_write_select_n <= bw;
        address <= a;
        burstOrder <= order;
        outputEnableN <= oeReq;
        sleep_request <= slpReq;
        #1;
        q = {parity_bus_out, dataOut};
        oe = {dataOe, parityBusOe};
    endtask
endmodule

/* File: testbench/tb_top.sv */
// self-checking bench for the pipelined burst sram core
// assumes the host model drives every sram input on the rising edge
`timescale 1ns/100ps

module tb_top;
    logic core_clk; // 100 MHz
    logic rst_b; // active low reset
    logic ordSel, oeReq, slpReq; // levels handed to the host model
    logic clock_qualify_n, chip_select_a_n, chip_select_b, chip_select_c_n;
    logic advance_or_load, writeEnableN, burstOrder, outputEnableN;
    logic sleep_request, dataOe, parityBusOe, hostClash;
    logic [3:0] byte_write_select_n, parity_bus_in, parity_bus_out;
    logic [5:0] address;
    logic [31:0] dataIn, dataOut;
    logic [35:0] q; // sram output word, parity on top
    logic [1:0] oe; // sram drive enables
    logic [35:0] mem [64]; // expected array contents
    int bad_count;
    int n_checks;

    // small address space keeps the expected array short
    pbs_burst_sram #(.ADDR_W(6)) dut_u (
        .core_clk(core_clk), .rst_b(rst_b),
        .clock_qualify_n(clock_qualify_n), .chip_select_a_n(chip_select_a_n),
        .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
        .advance_or_load(advance_or_load), .writeEnableN(writeEnableN),
        .byte_write_select_n(byte_write_select_n), .address(address),
        .burstOrder(burstOrder), .outputEnableN(outputEnableN),
        .sleep_request(sleep_request), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .parity_bus_in(parity_bus_in),
        .parity_bus_out(parity_bus_out), .parityBusOe(parityBusOe)
    );

    pbs_host_model host_u (
        .core_clk(core_clk), .order(ordSel), .oeReq(oeReq), .slpReq(slpReq),
        .clock_qualify_n(clock_qualify_n), .chip_select_a_n(chip_select_a_n),
        .chip_select_b(chip_select_b), .chip_select_c_n(chip_select_c_n),
        .advance_or_load(advance_or_load), .writeEnableN(writeEnableN),
        .byte_write_select_n(byte_write_select_n), .address(address),
        .burstOrder(burstOrder), .outputEnableN(outputEnableN),
        .sleep_request(sleep_request), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .parity_bus_in(parity_bus_in),
        .parity_bus_out(parity_bus_out), .parityBusOe(parityBusOe),
        .clash(hostClash)
    );

    // clock
    always #5 core_clk = ~core_clk;

    // compare and count
    task chk(input string nm, input logic [37:0] e, input logic [37:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask
    // bus must float
    task off(input string nm);
        chk(nm, 38'h00_0000_0000, 38'(oe));
    endtask
    // bus must carry e
    task got(input string nm, input logic [35:0] e);
        chk(nm, {2'h3, e}, {oe, q});
    endtask

    // bus cycle shorthands; an answer shows two calls later
    task op(input logic cq, adv, sel, wen, wrt, input logic [5:0] a,
        input logic [3:0] bw, input logic [35:0] wd);
        host_u.op(cq, adv, sel, wen, wrt, a, bw, wd, q, oe);
    endtask
    task nop;
        op(0, 0, 0, 1, 0, 6'h00, 4'hf, 36'h0_0000_0000);
    endtask
    task rd(input logic [5:0] a);
        op(0, 0, 1, 1, 0, a, 4'hf, 36'h0_0000_0000);
    endtask
    task wr(input logic [5:0] a, input logic [3:0] bw, input logic [35:0] d);
        op(0, 0, 1, 0, 1, a, bw, d);
    endtask

    // lanes whose select is low take the new byte and parity bit
    function automatic logic [35:0] mrg(input logic [35:0] o, w,
        input logic [3:0] bw);
        logic [35:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (!bw[i]) begin
                r[8*i+:8] = w[8*i+:8];
                r[32+i] = w[32+i];
            end
        end
        return r;
    endfunction

    // low two address bits of beat k
    function automatic logic [1:0] beat(input logic o, input logic [1:0] s,
        input int k);
        return o ? (s ^ 2'(k)) : (s + 2'(k));
    endfunction

    // write, read back to back, byte write, aborted write
    task t_single;
        wr(6'h05, 4'h0, 36'h5_a5a5_1234);
        mem[5] = 36'h5_a5a5_1234;
        rd(6'h05);
        wr(6'h05, 4'h5, 36'ha_0f0f_0f0f);
        off("write data cycle");
        wr(6'h05, 4'hf, 36'h0_0000_0000);
        got("forwarded read", mem[5]);
        mem[5] = mrg(mem[5], 36'ha_0f0f_0f0f, 4'h5);
        rd(6'h05);
        off("write data cycle");
        nop;
        off("aborted write cycle");
        nop;
        got("byte write", mem[5]);
        nop;
        off("after deselect");
    endtask

    // output enable high keeps a read off the bus
    task t_oe;
        oeReq = 1'b1;
        repeat (3) nop;
        rd(6'h05);
        nop;
        nop;
        off("read with enable high");
        oeReq = 1'b0;
        repeat (3) nop;
    endtask

    // frozen edge neither loads nor moves the answer
    task t_freeze;
        rd(6'h05);
        op(1, 0, 1, 1, 0, 6'h21, 4'hf, 36'h0_0000_0000);
        nop;
        off("frozen edge");
        nop;
        got("read after freeze", mem[5]);
        nop;
        off("after deselect");
    endtask

    // four beat write, then five beat read that wraps
    task t_burst(input logic o, input logic [1:0] s);
        logic [35:0] wd;
        logic [5:0] base;
        base = {4'h2, s};
        ordSel = o;
        for (int k = 0; k < 4; k++) begin
            wd = 36'h9_1234_5600 + 36'(16 * k + 4 * s + o);
            mem[{4'h2, beat(o, s, k)}] = wd;
            op(0, k != 0, k == 0, k != 0, 1, base, 4'h0, wd);
            if (k >= 2) off("burst write cycle");
        end
        nop;
        off("burst write cycle");
        rd(base);
        off("burst write cycle");
        for (int j = 0; j < 7; j++) begin
            if (j < 4) op(0, 1, 0, 0, 0, 6'h3f, 4'h0, 36'h0_0000_0000);
            else nop;
            if (j >= 1 && j <= 5)
                got("burst beat", mem[{4'h2, beat(o, s, j - 1)}]);
            else if (j == 6) off("burst end");
        end
    endtask

    // data survives sleep; nothing answers while asleep
    task t_sleep;
        wr(6'h07, 4'h0, 36'h3_c3c3_7777);
        mem[7] = 36'h3_c3c3_7777;
        repeat (3) nop;
        slpReq = 1'b1;
        repeat (6) nop;
        rd(6'h07);
        nop;
        nop;
        off("read while asleep");
        slpReq = 1'b0;
        repeat (8) nop;
        rd(6'h07);
        nop;
        nop;
        got("kept through sleep", mem[7]);
    endtask

    // verdict and end of run
    task complete_run;
        if (bad_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {core_clk, rst_b, ordSel, oeReq, slpReq} = 5'h00;
        bad_count = 0;
        n_checks = 0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        nop;
        off("after reset");
        repeat (2) nop;
        t_single;
        t_oe;
        t_freeze;
        for (int i = 0; i < 4; i++) t_burst(i[0], {i[1], 1'b1});
        t_sleep;
        chk("host drive fight", 38'h00_0000_0000, 38'(hostClash));
        complete_run;
    end

    // hang guard
    initial begin
        repeat (3000) @(posedge core_clk);
        bad_count++;
        complete_run;
    end
endmodule
